//--- core/boot_table_loader.sv
// Purpose: Boot table loader: header decode, one section into RAM block zero
// Assumes: Byte stream from parallel port or serial receiver on pclk; APB host
// Notes:   Two-entry buffer before the RAM write port absorbs RAM stalls
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "boot_loader_cfg.svh"

module boot_table_loader (
  // APB slave
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic [31:0]                       prdata,
  // Boot byte stream (parallel port or serial receiver)
  input  wire logic                         src_valid,
  input  wire logic [15:0]                  src_data,
  output logic                              src_ready,
  // Global memory read for EPROM boot
  output logic                              eprom_rd,
  output logic [15:0]                       eprom_addr,
  input  wire logic                         eprom_ack,
  input  wire logic [7:0]                   eprom_data,
  // RAM block zero write port
  output logic                              ram_we,
  output boot_loader_pkg::ram_word_t        ram_word,
  input  wire logic                         ram_ready,
  // Configuration results
  output logic [`CFG_MASK_MSB:0]            interrupt_mask_reg,
  output boot_loader_pkg::mem_map_t         mem_map,
  output logic                              exec_start,
  output logic [15:0]                       exec_addr
);

  boot_loader_pkg::load_state_t state_r;
  boot_loader_pkg::src_mode_t   src_r;
  boot_loader_pkg::ram_word_t   buf_r [0:1];
  boot_loader_pkg::ram_word_t   push_word;
  logic [`LEN_W-1:0]            len_r;
  logic [`LEN_W-1:0]            count_r;
  logic [`LEN_W-1:0]            eprom_len_r;
  logic [7:0]                   lo_byte_r;
  logic [7:0]                   cfg_r;
  logic [2:0]                   len_hi_r;
  logic                         wide_r;
  logic                         done_r;
  logic                         abandon_r;
  logic [1:0]                   buf_cnt_r;
  logic                         buf_wptr_r;
  logic                         buf_rptr_r;
  logic                         push;
  logic                         pop;
  logic                         buf_full;
  logic                         take;
  logic                         start;
  logic                         busy;
  logic                         wr_access;
  logic                         mapped;
  logic [31:0]                  rd_nxt;

  // APB decode: zero wait states, reads captured in the setup cycle
  assign pready    = 1'b1;
  assign wr_access = psel & penable & pwrite;
  assign mapped    = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) | (paddr == `REG_CONFIG)
                   | (paddr == `REG_EPROM_LEN) | (paddr == `REG_ENTRY);
  assign pslverr   = psel & penable & ~mapped;
  assign busy      = (state_r != boot_loader_pkg::ST_IDLE);
  // Start while busy is dropped: one section per boot
  assign start     = wr_access & (paddr == `REG_CTRL) & pwdata[`CTRL_START_BIT] & ~busy;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (paddr)
      `REG_CTRL:      rd_nxt[`CTRL_SRC_MSB:`CTRL_SRC_LSB] = src_r;
      `REG_STATUS:    rd_nxt = {16'h0000, 1'b0, count_r, abandon_r, done_r, wide_r, busy};
      `REG_CONFIG:    rd_nxt[7:0] = cfg_r;
      `REG_EPROM_LEN: rd_nxt[`LEN_W-1:0] = eprom_len_r;
      `REG_ENTRY:     rd_nxt[15:0] = exec_addr;
      default:        rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r       <= boot_loader_pkg::SRC_PARALLEL;
      eprom_len_r <= `EPROM_LEN_RST;
    end else if (wr_access & ~busy) begin
      if (paddr == `REG_CTRL) begin
        src_r <= boot_loader_pkg::src_mode_t'(pwdata[`CTRL_SRC_MSB:`CTRL_SRC_LSB]);
      end
      if (paddr == `REG_EPROM_LEN) begin
        eprom_len_r <= pwdata[`LEN_W-1:0];
      end
    end
  end

  // Byte taken from the stream this cycle; data bytes wait for buffer room
  always_comb begin
    src_ready = 1'b0;
    unique case (state_r)
      boot_loader_pkg::ST_RATE, boot_loader_pkg::ST_STATUS, boot_loader_pkg::ST_CONFIG,
      boot_loader_pkg::ST_LENGTH, boot_loader_pkg::ST_SYNC: src_ready = 1'b1;
      boot_loader_pkg::ST_DATA_LO, boot_loader_pkg::ST_DATA_HI: src_ready = ~buf_full;
      default: src_ready = 1'b0;
    endcase
  end
  assign take = src_valid & src_ready;

  // Word assembly: byte-wide stream low byte first, EPROM high byte first
  always_comb begin
    push              = 1'b0;
    push_word.addr    = count_r;
    push_word.data    = src_data;
    unique case (state_r)
      boot_loader_pkg::ST_DATA_LO: begin
        push = take & wide_r;
      end
      boot_loader_pkg::ST_DATA_HI: begin
        push           = take;
        push_word.data = {src_data[7:0], lo_byte_r};
      end
      boot_loader_pkg::ST_EP_LO: begin
        // A stray answer while the read is held off must not overrun the buffer
        push           = eprom_ack & ~buf_full;
        push_word.data = {lo_byte_r, eprom_data};
      end
      default: push = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= boot_loader_pkg::ST_IDLE;
      len_hi_r  <= 3'h0;
      len_r     <= {`LEN_W{1'b0}};
      count_r   <= {`LEN_W{1'b0}};
      lo_byte_r <= 8'h00;
      wide_r    <= 1'b0;
      done_r    <= 1'b0;
      abandon_r <= 1'b0;
    end else begin
      if (push) begin
        count_r <= count_r + `LEN_W'(1);
      end
      unique case (state_r)
        boot_loader_pkg::ST_IDLE: begin
          if (start) begin
            done_r    <= 1'b0;
            abandon_r <= 1'b0;
            count_r   <= {`LEN_W{1'b0}};
            wide_r    <= 1'b0;
            if (src_r == boot_loader_pkg::SRC_EPROM) begin
              len_r   <= eprom_len_r;
              state_r <= (eprom_len_r == {`LEN_W{1'b0}}) ? boot_loader_pkg::ST_DRAIN
                                                         : boot_loader_pkg::ST_EP_HI;
            end else if (src_r == boot_loader_pkg::SRC_SERIAL) begin
              state_r <= boot_loader_pkg::ST_RATE;
            end else begin
              state_r <= boot_loader_pkg::ST_STATUS;
            end
          end
        end
        boot_loader_pkg::ST_RATE: begin
          // Bytes without the top bit are skipped while the line settles
          if (take & src_data[`RATE_TOP_BIT]) begin
            state_r <= boot_loader_pkg::ST_STATUS;
          end
        end
        boot_loader_pkg::ST_STATUS: begin
          if (take) begin
            len_hi_r <= src_data[`STAT_LEN_MSB:`STAT_LEN_LSB];
            // Wide transfers only exist on the parallel port; bits 7:5 are dropped
            wide_r   <= src_data[`STAT_WIDE_BIT] & (src_r == boot_loader_pkg::SRC_PARALLEL);
            state_r  <= src_data[`STAT_ENABLE_BIT] ? boot_loader_pkg::ST_CONFIG
                                                  : boot_loader_pkg::ST_ABORT;
          end
        end
        boot_loader_pkg::ST_CONFIG: begin
          if (take) begin
            state_r <= boot_loader_pkg::ST_LENGTH;
          end
        end
        boot_loader_pkg::ST_LENGTH: begin
          if (take) begin
            len_r   <= {len_hi_r, src_data[7:0]};
            state_r <= ({len_hi_r, src_data[7:0]} == {`LEN_W{1'b0}}) ? boot_loader_pkg::ST_SYNC
                                                                     : boot_loader_pkg::ST_DATA_LO;
          end
        end
        boot_loader_pkg::ST_DATA_LO: begin
          if (take) begin
            lo_byte_r <= src_data[7:0];
            if (!wide_r) begin
              state_r <= boot_loader_pkg::ST_DATA_HI;
            end else if (count_r == len_r - `LEN_W'(1)) begin
              state_r <= boot_loader_pkg::ST_SYNC;
            end
          end
        end
        boot_loader_pkg::ST_DATA_HI: begin
          if (take) begin
            state_r <= (count_r == len_r - `LEN_W'(1)) ? boot_loader_pkg::ST_SYNC
                                                       : boot_loader_pkg::ST_DATA_LO;
          end
        end
        boot_loader_pkg::ST_SYNC: begin
          if (take) begin
            state_r <= boot_loader_pkg::ST_DRAIN;
          end
        end
        boot_loader_pkg::ST_EP_HI: begin
          if (eprom_ack) begin
            lo_byte_r <= eprom_data;
            state_r   <= boot_loader_pkg::ST_EP_LO;
          end
        end
        boot_loader_pkg::ST_EP_LO: begin
          if (eprom_ack & ~buf_full) begin
            state_r <= (count_r == len_r - `LEN_W'(1)) ? boot_loader_pkg::ST_DRAIN
                                                       : boot_loader_pkg::ST_EP_HI;
          end
        end
        boot_loader_pkg::ST_DRAIN: begin
          // Done only once the last word has left the buffer
          if (buf_cnt_r == 2'h0) begin
            done_r  <= 1'b1;
            state_r <= boot_loader_pkg::ST_IDLE;
          end
        end
        boot_loader_pkg::ST_ABORT: begin
          abandon_r <= 1'b1;
          state_r   <= boot_loader_pkg::ST_IDLE;
        end
        default: state_r <= boot_loader_pkg::ST_IDLE;
      endcase
    end
  end

  // Configuration byte applied as it arrives; no RAM write happens in the header
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= 8'h00;
    end else if ((state_r == boot_loader_pkg::ST_CONFIG) & take) begin
      cfg_r <= src_data[7:0];
    end
  end

  assign interrupt_mask_reg = cfg_r[`CFG_MASK_MSB:0];

  // Blocks: bit 0 ram_block_zero .. bit 3 ram_block_three; code 11 falls back to 00
  always_comb begin
    unique case (cfg_r[`CFG_MAP_MSB:`CFG_MAP_LSB])
      2'h1:    mem_map = '{prog: 4'h3, data: 4'h4};
      2'h2:    mem_map = '{prog: 4'hb, data: 4'h0};
      default: mem_map = '{prog: 4'h1, data: 4'h6};
    endcase
  end

  // EPROM read: request held until acknowledged
  assign eprom_rd   = (state_r == boot_loader_pkg::ST_EP_HI) | ((state_r == boot_loader_pkg::ST_EP_LO) & ~buf_full);
  assign eprom_addr = `EPROM_BASE + {4'h0, count_r, (state_r == boot_loader_pkg::ST_EP_LO)};

  // Start pulse one cycle after the last word is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_start <= 1'b0;
    end else begin
      exec_start <= (state_r == boot_loader_pkg::ST_DRAIN) & (buf_cnt_r == 2'h0);
    end
  end
  assign exec_addr = `RAM_B0_BASE;

  // Two-entry buffer between assembly and the RAM port
  assign buf_full = (buf_cnt_r == `BUF_DEPTH);
  assign ram_we   = (buf_cnt_r != 2'h0);
  assign ram_word = buf_r[buf_rptr_r];
  assign pop      = ram_we & ram_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_cnt_r  <= 2'h0;
      buf_wptr_r <= 1'b0;
      buf_rptr_r <= 1'b0;
    end else begin
      if (push) begin
        buf_wptr_r <= ~buf_wptr_r;
      end
      if (pop) begin
        buf_rptr_r <= ~buf_rptr_r;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_buf
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          buf_r[i] <= '0;
        end else if (push & (buf_wptr_r == 1'(i))) begin
          buf_r[i] <= push_word;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- inc/boot_loader_cfg.svh
// Purpose: Named constants for the boot table loader
// Assumes: Included by bare name from the loader package and core
// Notes:   Definitions only
`ifndef BOOT_LOADER_CFG_SVH
`define BOOT_LOADER_CFG_SVH

// Register byte addresses
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_CONFIG      8'h08
`define REG_EPROM_LEN   8'h0c
`define REG_ENTRY       8'h10

// Control register fields
`define CTRL_START_BIT  0
`define CTRL_SRC_LSB    1
`define CTRL_SRC_MSB    2

// Header status byte fields and the rate byte's top bit
`define STAT_LEN_MSB    2
`define STAT_LEN_LSB    0
`define STAT_ENABLE_BIT 3
`define STAT_WIDE_BIT   4
`define RATE_TOP_BIT    7

// Configuration byte fields
`define CFG_MASK_MSB    5
`define CFG_MAP_MSB     7
`define CFG_MAP_LSB     6

// Sizes and addresses
`define LEN_W           11
`define EPROM_BASE      16'h8000
`define EPROM_LEN_RST   11'h000
`define RAM_B0_BASE     16'h0200
`define BUF_DEPTH       2'h2

`endif

//--- inc/boot_loader_pkg.sv
// Purpose: Types shared by the boot table loader
// Assumes: Constants come from boot_loader_cfg.svh
// Notes:   No logic here
`default_nettype none
`include "boot_loader_cfg.svh"

package boot_loader_pkg;

  typedef enum logic [1:0] {
    SRC_PARALLEL = 2'h0,
    SRC_SERIAL   = 2'h1,
    SRC_EPROM    = 2'h2
  } src_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_RATE    = 4'h1,
    ST_STATUS  = 4'h2,
    ST_CONFIG  = 4'h3,
    ST_LENGTH  = 4'h4,
    ST_DATA_LO = 4'h5,
    ST_DATA_HI = 4'h6,
    ST_SYNC    = 4'h7,
    ST_EP_HI   = 4'h8,
    ST_EP_LO   = 4'h9,
    ST_DRAIN   = 4'ha,
    ST_ABORT   = 4'hb
  } load_state_t;

  typedef struct packed {
    logic [`LEN_W-1:0] addr;
    logic [15:0]       data;
  } ram_word_t;

  typedef struct packed {
    logic [3:0] prog;
    logic [3:0] data;
  } mem_map_t;

endpackage

`default_nettype wire

//--- tb/boot_eprom_model.sv
// Purpose: Byte-wide boot memory model on the global read port
// Assumes: Image byte at offset b holds b ^ 5a
// Notes:   Even bytes answer at once, odd bytes two cycles late
`timescale 1ns/10ps
`default_nettype none

module boot_eprom_model (
  // Global memory read
  input  wire logic        pclk,
  input  wire logic        eprom_rd,
  input  wire logic [15:0] eprom_addr,
  output logic             eprom_ack,
  output logic [7:0]       eprom_data
);
  logic [1:0] wait_r = 2'h0;
  logic [7:0] byte_v;

  always @(posedge pclk) begin
    if (eprom_rd && !eprom_ack) wait_r <= wait_r + 2'h1;
    else wait_r <= 2'h0;
  end

  // Only the window from 8000h answers; elsewhere the read hangs
  assign eprom_ack = eprom_rd && eprom_addr[15] && wait_r == {eprom_addr[0], 1'b0};
  assign byte_v = eprom_addr[7:0] ^ 8'h5a;
  // Bus carries the inverted byte outside an answer
  assign eprom_data = eprom_ack ? byte_v : ~byte_v;
endmodule

`default_nettype wire

//--- tb/boot_table_loader_assertions.sv
// Purpose: Concurrent checks on the boot table loader ports
// Assumes: Bound to every boot_table_loader instance
// Notes:   One clock domain, async active-low reset
`timescale 1ns/10ps
`default_nettype none
`include "boot_loader_cfg.svh"

module boot_table_loader_assertions (
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // APB
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic [7:0]                 paddr,
  input wire logic                       pslverr,
  // Stream and global memory
  input wire logic                       src_valid,
  input wire logic                       src_ready,
  input wire logic                       eprom_rd,
  input wire logic [15:0]                eprom_addr,
  input wire logic                       eprom_ack,
  // RAM and results
  input wire logic                       ram_we,
  input wire boot_loader_pkg::ram_word_t ram_word,
  input wire logic                       ram_ready,
  input wire logic [`CFG_MASK_MSB:0]     interrupt_mask_reg,
  input wire boot_loader_pkg::mem_map_t  mem_map,
  input wire logic                       exec_start,
  input wire logic [15:0]                exec_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Address the next gap-free RAM write must carry
  logic [`LEN_W-1:0] next_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) next_r <= '0;
    else if (exec_start) next_r <= '0;
    else if (ram_we && ram_ready) next_r <= next_r + 11'h001;
  end

  sequence s_hi_taken;
    eprom_rd && eprom_ack && !eprom_addr[0];
  endsequence
  // Read may be held off by a full buffer, but the address must already name the low byte
  sequence s_lo_read;
    eprom_addr[0] && !src_ready;
  endsequence

  a_apb_unmapped: assert property (psel && penable |->
    pslverr == (paddr > `REG_ENTRY || paddr[1:0] != 2'h0)) else $error("bad pslverr");
  a_eprom_hold: assert property (eprom_rd && !eprom_ack |=> eprom_rd && $stable(eprom_addr))
    else $error("read released early");
  a_eprom_window: assert property (eprom_rd |-> eprom_addr >= `EPROM_BASE && !src_ready)
    else $error("read outside boot window");
  a_eprom_order: assert property (s_hi_taken |=> s_lo_read) else $error("low byte not next");
  a_ram_sequential: assert property (ram_we |-> ram_word.addr == next_r) else $error("ram gap");
  a_ram_stall_hold: assert property (ram_we && !ram_ready |=> ram_we && $stable(ram_word))
    else $error("word lost in stall");
  a_start_drained: assert property (exec_start |-> !ram_we && exec_addr == `RAM_B0_BASE)
    else $error("bad start");
  a_start_once: assert property (exec_start |=> !exec_start [*8]) else $error("start repeated");
  a_config_cause: assert property ($changed(interrupt_mask_reg) || $changed(mem_map) |->
    $past(src_valid && src_ready) || $past(src_valid && src_ready, 2)) else $error("config without byte");
endmodule

bind boot_table_loader boot_table_loader_assertions u_chk (.*);

`default_nettype wire

//--- tb/boot_table_loader_tb.sv
// Purpose: Self-checking bench for the boot table loader
// Assumes: Stream sent here, global memory by boot_eprom_model
// Notes:   RAM stalls 8 of 32 cycles so the buffer fills
`timescale 1ns/10ps
`default_nettype none
`include "boot_loader_cfg.svh"

module boot_table_loader_tb;
  logic                       pclk;
  logic                       presetn;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [7:0]                 paddr;
  logic [31:0]                pwdata;
  logic                       pready;
  logic                       pslverr;
  logic [31:0]                prdata;
  logic                       src_valid;
  logic [15:0]                src_data;
  logic                       src_ready;
  logic                       eprom_rd;
  logic [15:0]                eprom_addr;
  logic                       eprom_ack;
  logic [7:0]                 eprom_data;
  logic                       ram_we;
  boot_loader_pkg::ram_word_t ram_word;
  logic                       ram_ready;
  logic [`CFG_MASK_MSB:0]     interrupt_mask_reg;
  boot_loader_pkg::mem_map_t  mem_map;
  logic                       exec_start;
  logic [15:0]                exec_addr;
  logic [31:0]                rd_q;
  logic                       err_q;
  logic [26:0]                got[$];
  int                         cyc;
  int                         bad_count;
  int                         n_tests;

  boot_table_loader uut (.*);
  boot_eprom_model u_ep (.*);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ram_ready <= cyc[4:3] != 2'h0;
    if (ram_we === 1'b1 && ram_ready === 1'b1) got.push_back(ram_word);
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Valid stays up between bytes; caller drops it after the last
  task automatic put(input logic [15:0] d);
    src_valid <= 1'b1;
    src_data <= d;
    do @(posedge pclk); while (src_ready !== 1'b1);
  endtask

  function automatic logic [7:0] emap(input logic [1:0] c);
    case (c)
      2'h1: return 8'h34;
      2'h2: return 8'hb0;
      default: return 8'h16;
    endcase
  endfunction

  task automatic boot_stream(input logic ser, input logic wide, input logic [7:0] cfg, input logic [10:0] n);
    logic [15:0] w;
    got.delete();
    // Start samples the stored source, so the source goes in first
    apb(1'b1, `REG_CTRL, {30'h0, ser, 1'b0});
    apb(1'b1, `REG_CTRL, {30'h0, ser, 1'b1});
    if (ser) begin
      put(16'h0011);
      put(16'h0080);
    end
    put({8'h0, 3'h5, wide, 1'b1, n[10:8]});
    put({8'h0, cfg});
    put({8'h0, n[7:0]});
    for (int k = 0; k < n; k++) begin
      w = {k[7:0] ^ 8'ha5, k[7:0]};
      if (wide) put(w);
      else begin
        put({8'h0, w[7:0]});
        put({8'h0, w[15:8]});
      end
    end
    put(16'h00e7);
    src_valid <= 1'b0;
    src_data <= 16'h1818;
    do @(posedge pclk); while (exec_start !== 1'b1);
    @(posedge pclk);
    chk(src_ready, 1'b0);
    chk(got.size(), n);
    for (int k = 0; k < got.size(); k++) chk(got[k], {k[10:0], k[7:0] ^ 8'ha5, k[7:0]});
    chk(interrupt_mask_reg, cfg[5:0]);
    chk(mem_map, emap(cfg[7:6]));
    apb(1'b0, `REG_STATUS, 32'h0);
    chk(rd_q[14:0], {n, 2'h1, wide, 1'b0});
    apb(1'b0, `REG_CONFIG, 32'h0);
    chk(rd_q, {24'h0, cfg});
  endtask

  task automatic boot_abandon();
    got.delete();
    apb(1'b1, `REG_CTRL, 32'h1);
    put(16'h00f3);
    src_valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(src_ready, 1'b0);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk({rd_q[14:3], 20'(got.size())}, {12'h001, 20'h00000});
  endtask

  task automatic boot_eprom();
    got.delete();
    apb(1'b1, `REG_EPROM_LEN, 32'h3);
    apb(1'b1, `REG_CTRL, 32'h4);
    apb(1'b1, `REG_CTRL, 32'h5);
    do @(posedge pclk); while (exec_start !== 1'b1);
    chk(got.size(), 3);
    for (int k = 0; k < 3; k++) chk(got[k], {k[10:0], 8'(2 * k) ^ 8'h5a, 8'(2 * k + 1) ^ 8'h5a});
  endtask

  task automatic reg_access();
    apb(1'b1, `REG_ENTRY, 32'hffff);
    apb(1'b0, `REG_ENTRY, 32'h0);
    chk({err_q, rd_q}, {17'h0, `RAM_B0_BASE});
    apb(1'b0, 8'h40, 32'h0);
    chk({err_q, rd_q}, 33'h100000000);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_valid = 1'b0;
    src_data = 16'h0;
    repeat (8) @(posedge pclk);
    chk({interrupt_mask_reg, mem_map, exec_start}, {6'h0, 8'h16, 1'b0});
    presetn <= 1'b1;
    boot_stream(1'b1, 1'b0, 8'h3f, 11'h003);
    boot_stream(1'b0, 1'b1, 8'h55, 11'h004);
    boot_stream(1'b0, 1'b0, 8'h8a, 11'h001);
    boot_stream(1'b0, 1'b0, 8'hc0, 11'h000);
    boot_abandon();
    boot_eprom();
    reg_access();
    end_sim();
  end
endmodule

`default_nettype wire
